// >>> jpm_ctrl.sv
`timescale 1ns/1ps
// How it works
// - tms never becomes a user pin
// - dedicated mode: pins test only, pull-ups
// - flexible mode: shared pins, no tms/tdi pull-ups
// - power-up puts tap in reset state
// - flexible: user pins only in reset
// - tms low at tck rise claims pins
// - five tms-high cycles reach reset state
// - test reset option: async reset, pull-up
// - no test reset option: trst user pin
// - host selects nets onto two probe pins
// - probing takes tdi, tck, tdo, probe pins
// - security fuse disables probing
// - probe reservation keeps or frees pins
module jpm_ctrl
  import jpm_pkg::*;
(
  input wire logic SYS_CLK,                 // system clock, 20 mhz
  input wire logic RST,                     // sync reset, system domain
  input wire logic CE,                      // clock enable, both domains
  input wire logic TCK,                     // scan clock, link domain
  input wire logic TMS,                     // test mode select pin
  input wire logic TDI,                     // test data in pin
  input wire logic TRST_IN,                 // test reset pin level
  input wire logic POR,                     // power-up reset, async
  input wire logic CFG_RESERVE_JTAG,        // dedicated mode select
  input wire logic CFG_RESERVE_TRST,        // test reset option
  input wire logic CFG_RESERVE_PROBE,       // reserve probe pins
  input wire logic SECURITY_FUSE,           // fuse programmed
  input wire logic [NET_N-1:0] NETS,        // internal nets, sys domain
  input wire logic USR_TDO_OUT,             // design drive for tdo pin
  input wire logic USR_TDO_OE,              // design enable for tdo pin
  input wire logic USR_TRST_OUT,            // design drive for trst pin
  input wire logic USR_TRST_OE,             // design enable for trst pin
  input wire logic USR_PROBE_A_OUT,         // design drive, probe a pin
  input wire logic USR_PROBE_A_OE,          // design enable, probe a pin
  input wire logic USR_PROBE_B_OUT,         // design drive, probe b pin
  input wire logic USR_PROBE_B_OE,          // design enable, probe b pin
  output logic TDO_OUT,                     // tdo pin drive
  output logic TDO_OE,                      // tdo pin enable
  output logic TRST_OUT,                    // trst pin drive
  output logic TRST_OE,                     // trst pin enable
  output logic PROBE_OUT_A,                 // probe a pin drive
  output logic PROBE_OE_A,                  // probe a pin enable
  output logic PROBE_OUT_B,                 // probe b pin drive
  output logic PROBE_OE_B,                  // probe b pin enable
  output logic TMS_PULLUP_EN,               // internal pull-up on tms
  output logic TDI_PULLUP_EN,               // internal pull-up on tdi
  output logic TRST_PULLUP_EN,              // internal pull-up on trst
  output logic TMS_USER_AVAIL,              // tms usable as user i/o
  output logic SHARED_USER_AVAIL,           // tdi/tck/tdo are user i/o
  output logic PROBE_PINS_USER_AVAIL,       // probe pins are user i/o
  output logic PROBE_ACTIVE,                // probing running, sys domain
  output logic [jpm_pkg::NET_N-1:0] USR_IN_VALID  // user input valid
);

  ////////////////////////////////////////////////////////////////////
  // link domain state, clocked by tck
  typedef struct packed {
    jpm_tap_t tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [PSR_W-1:0] dr_sh;
    logic [PSR_W-1:0] psel;
    logic tdo;
    logic tdo_en;
    logic sel_tgl;  // flips on every select change
  } jpm_link_t;

  jpm_link_t lk_ff;
  jpm_link_t nxt_lk;
  logic tap_arst;

  // trst acts only when the option is reserved; low level resets
  assign tap_arst = POR | (CFG_RESERVE_TRST & ~TRST_IN);

  // tap graph, shift registers and tdo
  always_comb begin
    nxt_lk = lk_ff;
    // state graph: tms high from any state walks toward reset
    case (lk_ff.tap)
      // reset: tms low at a tck rise leaves it and claims pins
      TAP_RESET: begin
        nxt_lk.tap = TMS ? TAP_RESET : TAP_IDLE;
      end
      // idle: parks here between scans
      TAP_IDLE: begin
        nxt_lk.tap = TMS ? TAP_SEL_DR : TAP_IDLE;
      end
      // data register column
      TAP_SEL_DR: begin
        nxt_lk.tap = TMS ? TAP_SEL_IR : TAP_CAP_DR;
      end
      TAP_CAP_DR: begin
        nxt_lk.tap = TMS ? TAP_EX1_DR : TAP_SHF_DR;
      end
      TAP_SHF_DR: begin
        nxt_lk.tap = TMS ? TAP_EX1_DR : TAP_SHF_DR;
      end
      TAP_EX1_DR: begin
        nxt_lk.tap = TMS ? TAP_UPD_DR : TAP_PAU_DR;
      end
      TAP_PAU_DR: begin
        nxt_lk.tap = TMS ? TAP_EX2_DR : TAP_PAU_DR;
      end
      TAP_EX2_DR: begin
        nxt_lk.tap = TMS ? TAP_UPD_DR : TAP_SHF_DR;
      end
      TAP_UPD_DR: begin
        nxt_lk.tap = TMS ? TAP_SEL_DR : TAP_IDLE;
      end
      // instruction register column
      TAP_SEL_IR: begin
        nxt_lk.tap = TMS ? TAP_RESET : TAP_CAP_IR;
      end
      TAP_CAP_IR: begin
        nxt_lk.tap = TMS ? TAP_EX1_IR : TAP_SHF_IR;
      end
      TAP_SHF_IR: begin
        nxt_lk.tap = TMS ? TAP_EX1_IR : TAP_SHF_IR;
      end
      TAP_EX1_IR: begin
        nxt_lk.tap = TMS ? TAP_UPD_IR : TAP_PAU_IR;
      end
      TAP_PAU_IR: begin
        nxt_lk.tap = TMS ? TAP_EX2_IR : TAP_PAU_IR;
      end
      TAP_EX2_IR: begin
        nxt_lk.tap = TMS ? TAP_UPD_IR : TAP_SHF_IR;
      end
      TAP_UPD_IR: begin
        nxt_lk.tap = TMS ? TAP_SEL_DR : TAP_IDLE;
      end
      // an illegal code falls back to reset
      default: begin
        nxt_lk.tap = TAP_RESET;
      end
    endcase
    // register actions per state
    case (lk_ff.tap)
      TAP_RESET: begin
        nxt_lk.ir = IR_RST;
        nxt_lk.psel = PSR_RST;
      end
      TAP_CAP_IR: nxt_lk.ir_sh = IR_CAP;
      TAP_SHF_IR: nxt_lk.ir_sh = {TDI, lk_ff.ir_sh[IR_W-1:1]};
      TAP_UPD_IR: nxt_lk.ir = lk_ff.ir_sh;
      TAP_CAP_DR: nxt_lk.dr_sh = lk_ff.psel;
      TAP_SHF_DR: begin
        if (lk_ff.ir == IR_PROBE) begin
          nxt_lk.dr_sh = {TDI, lk_ff.dr_sh[PSR_W-1:1]};
        end else begin
          nxt_lk.dr_sh = {{(PSR_W-1){1'b0}}, TDI}; // bypass bit
        end
      end
      TAP_UPD_DR: begin
        if (lk_ff.ir == IR_PROBE) begin
          nxt_lk.psel = lk_ff.dr_sh;
        end
      end
      default: nxt_lk.tap = nxt_lk.tap;
    endcase
    nxt_lk.tdo = (lk_ff.tap == TAP_SHF_IR) ? lk_ff.ir_sh[0] : lk_ff.dr_sh[0];
    nxt_lk.tdo_en = (lk_ff.tap == TAP_SHF_IR) || (lk_ff.tap == TAP_SHF_DR);
    // toggle tells the system side that a new select is standing
    nxt_lk.sel_tgl = lk_ff.sel_tgl ^ (nxt_lk.psel != lk_ff.psel);
  end

  // tap register; tdo is registered on the rising tck edge with the rest
  always_ff @(posedge TCK or posedge tap_arst) begin
    if (tap_arst) begin
      // constants only; power-up or test reset lands in reset state
      lk_ff <= '{tap: TAP_RESET,
                 ir_sh: IR_RST,
                 ir: IR_RST,
                 dr_sh: PSR_RST,
                 psel: PSR_RST,
                 tdo: 1'b0,
                 tdo_en: 1'b0,
                 sel_tgl: 1'b0};
    end else if (CE) begin
      lk_ff <= nxt_lk;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // system domain state
  typedef struct packed {
    logic tlr_s1;
    logic tlr_s2;
    logic prb_s1;
    logic prb_s2;
    logic tgl_s1;            // select toggle, first flop
    logic tgl_s2;            // select toggle, second flop
    logic tgl_s3;            // select toggle, edge memory
    logic [PSR_W-1:0] sel;   // select word, taken on toggle edge
    logic pa;
    logic pb;
  } jpm_sys_t;

  jpm_sys_t sy_ff;
  jpm_sys_t nxt_sy;
  logic tap_in_reset;
  logic probe_req;
  logic probe_on;

  assign tap_in_reset = (lk_ff.tap == TAP_RESET);
  assign probe_req = (lk_ff.ir == IR_PROBE) & ~SECURITY_FUSE;

  // two-flop crossing for flags; the select word itself crosses by a
  // toggle handshake so no half-updated word is ever sampled
  always_comb begin
    nxt_sy = sy_ff;
    nxt_sy.tlr_s1 = tap_in_reset;
    nxt_sy.tlr_s2 = sy_ff.tlr_s1;
    nxt_sy.prb_s1 = probe_req;
    nxt_sy.prb_s2 = sy_ff.prb_s1;
    nxt_sy.tgl_s1 = lk_ff.sel_tgl;
    nxt_sy.tgl_s2 = sy_ff.tgl_s1;
    nxt_sy.tgl_s3 = sy_ff.tgl_s2;
    // word has stood for two system clocks once the toggle shows
    if (sy_ff.tgl_s3 != sy_ff.tgl_s2) begin
      nxt_sy.sel = lk_ff.psel;
    end
    nxt_sy.pa = NETS[sy_ff.sel[SEL_W-1:0]];
    nxt_sy.pb = NETS[sy_ff.sel[PSR_W-1:SEL_W]];
  end

  // system domain register, frozen while the enable is low unless sync reset is high
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sy_ff <= '{tlr_s1: 1'b1,
                 tlr_s2: 1'b1,
                 prb_s1: 1'b0,
                 prb_s2: 1'b0,
                 tgl_s1: 1'b0,
                 tgl_s2: 1'b0,
                 tgl_s3: 1'b0,
                 sel: PSR_RST,
                 pa: 1'b0,
                 pb: 1'b0};
    end else if (CE) begin
      sy_ff <= nxt_sy;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin ownership
  assign probe_on = sy_ff.prb_s2 & ~SECURITY_FUSE;
  assign PROBE_ACTIVE = probe_on;
  assign TMS_USER_AVAIL = 1'b0;
  // dedicated: never user; flexible: user only in reset, not probing
  assign SHARED_USER_AVAIL = ~CFG_RESERVE_JTAG & sy_ff.tlr_s2
                             & ~probe_on;
  assign PROBE_PINS_USER_AVAIL = ~CFG_RESERVE_PROBE & ~probe_on;
  assign TMS_PULLUP_EN = CFG_RESERVE_JTAG;
  assign TDI_PULLUP_EN = CFG_RESERVE_JTAG;
  assign TRST_PULLUP_EN = CFG_RESERVE_TRST;
  assign USR_IN_VALID = {NET_N{SHARED_USER_AVAIL}};

  // tdo: scan data when in test use, else the design's drive
  always_comb begin
    if (SHARED_USER_AVAIL) begin
      TDO_OUT = USR_TDO_OUT;
      TDO_OE = USR_TDO_OE;
    end else begin
      TDO_OUT = lk_ff.tdo;
      TDO_OE = lk_ff.tdo_en;
    end
  end

  // trst: input only when reserved; user pin otherwise
  always_comb begin
    TRST_OUT = CFG_RESERVE_TRST ? 1'b0 : USR_TRST_OUT;
    TRST_OE = ~CFG_RESERVE_TRST & USR_TRST_OE;
  end

  // probe pins: probe data while probing, else design or idle
  always_comb begin
    if (probe_on) begin
      PROBE_OUT_A = sy_ff.pa;
      PROBE_OE_A = 1'b1;
      PROBE_OUT_B = sy_ff.pb;
      PROBE_OE_B = 1'b1;
    end else if (CFG_RESERVE_PROBE) begin
      PROBE_OUT_A = 1'b0;
      PROBE_OE_A = 1'b0;
      PROBE_OUT_B = 1'b0;
      PROBE_OE_B = 1'b0;
    end else begin
      PROBE_OUT_A = USR_PROBE_A_OUT;
      PROBE_OE_A = USR_PROBE_A_OE;
      PROBE_OUT_B = USR_PROBE_B_OUT;
      PROBE_OE_B = USR_PROBE_B_OE;
    end
  end

endmodule // jpm_ctrl

// >>> jpm_pkg.sv
package jpm_pkg;

  // tap controller states, one-hot codes
  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SHF_DR  = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PAU_DR  = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SHF_IR  = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PAU_IR  = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } jpm_tap_t;

  // instruction register
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_RST = 4'hf;  // bypass
  localparam logic [IR_W-1:0] IR_PROBE = 4'h9; // select probe nets
  localparam logic [IR_W-1:0] IR_CAP = 4'h1;   // capture pattern

  // probe select: two net indices
  localparam int NET_N = 16;
  localparam int SEL_W = 4;
  localparam int PSR_W = 2 * SEL_W;
  localparam logic [PSR_W-1:0] PSR_RST = 8'h00;

  // tms high cycles that always reach reset
  localparam int TLR_TMS_CYCLES = 5;

endpackage : jpm_pkg

// >>> jpm_ctrl_chk.sv
`timescale 1ns/1ps
module jpm_ctrl_chk
  import jpm_pkg::*;
(
  input wire logic SYS_CLK, // system clock
  input wire logic RST, // sync reset
  input wire logic CFG_RESERVE_JTAG, // dedicated mode
  input wire logic CFG_RESERVE_TRST, // trst option
  input wire logic CFG_RESERVE_PROBE, // probe pins kept
  input wire logic SECURITY_FUSE, // fuse programmed
  input wire logic USR_TRST_OUT, // user trst drive
  input wire logic USR_TRST_OE, // user trst enable
  input wire logic TRST_OUT, // trst drive
  input wire logic TRST_OE, // trst enable
  input wire logic PROBE_OE_A, // probe a enable
  input wire logic PROBE_OE_B, // probe b enable
  input wire logic TMS_PULLUP_EN, // tms pull-up
  input wire logic TDI_PULLUP_EN, // tdi pull-up
  input wire logic TRST_PULLUP_EN, // trst pull-up
  input wire logic TMS_USER_AVAIL, // tms as user pin
  input wire logic SHARED_USER_AVAIL, // shared pins user
  input wire logic PROBE_PINS_USER_AVAIL, // probe pins user
  input wire logic PROBE_ACTIVE // probing running
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  // probing switching on
  sequence s_probe_on;
    !PROBE_ACTIVE ##1 PROBE_ACTIVE;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // pin sharing relations
  a_tms_not_user: assert property (!TMS_USER_AVAIL)
    else $error("tms offered as user pin");
  a_ded_pins_test: assert property (CFG_RESERVE_JTAG &&
    $past(CFG_RESERVE_JTAG, 3) |-> TMS_PULLUP_EN && TDI_PULLUP_EN &&
    !SHARED_USER_AVAIL) else $error("dedicated mode pins wrong");
  a_flex_no_res: assert property (!CFG_RESERVE_JTAG |->
    !TMS_PULLUP_EN && !TDI_PULLUP_EN) else $error("flexible resistors on");
  a_trst_pull_on: assert property (TRST_PULLUP_EN == CFG_RESERVE_TRST)
    else $error("trst pull-up wrong");
  a_trst_user_pin: assert property (!CFG_RESERVE_TRST |->
    TRST_OUT == USR_TRST_OUT && TRST_OE == USR_TRST_OE)
    else $error("trst not user pin");
  a_fuse_blocks_probe: assert property (s_probe_on |-> !SECURITY_FUSE)
    else $error("probing with fuse set");
  a_probe_drive_pins: assert property (PROBE_ACTIVE |->
    PROBE_OE_A && PROBE_OE_B && !PROBE_PINS_USER_AVAIL)
    else $error("probe pins not driven");
  a_probe_resv_keep: assert property (CFG_RESERVE_PROBE |->
    !PROBE_PINS_USER_AVAIL) else $error("reserved probe pins free");
endmodule // jpm_ctrl_chk

bind jpm_ctrl jpm_ctrl_chk chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .CFG_RESERVE_JTAG(CFG_RESERVE_JTAG), .CFG_RESERVE_TRST(CFG_RESERVE_TRST),
  .CFG_RESERVE_PROBE(CFG_RESERVE_PROBE), .SECURITY_FUSE(SECURITY_FUSE),
  .USR_TRST_OUT(USR_TRST_OUT), .USR_TRST_OE(USR_TRST_OE),
  .TRST_OUT(TRST_OUT), .TRST_OE(TRST_OE), .PROBE_OE_A(PROBE_OE_A),
  .PROBE_OE_B(PROBE_OE_B), .TMS_PULLUP_EN(TMS_PULLUP_EN),
  .TDI_PULLUP_EN(TDI_PULLUP_EN), .TRST_PULLUP_EN(TRST_PULLUP_EN),
  .TMS_USER_AVAIL(TMS_USER_AVAIL), .SHARED_USER_AVAIL(SHARED_USER_AVAIL),
  .PROBE_PINS_USER_AVAIL(PROBE_PINS_USER_AVAIL), .PROBE_ACTIVE(PROBE_ACTIVE));

// >>> jpm_host.sv
`timescale 1ns/1ps
module jpm_host
  import jpm_pkg::*;
(
  output logic tck, // scan clock, still between frames
  output logic tms, // mode select
  output logic tdi // scan data
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one 64 ns scan clock, lines set while tck low
  task step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    #32 tck = 1'b0;
    tdi = ~d; // no stale data after the bit
  endtask
  // five tms-high clocks back to reset state
  task reset5();
    repeat (5) step(1'b1, 1'b0);
  endtask
  // tms low at a rising tck claims the pins
  task claim();
    step(1'b0, 1'b0);
  endtask
  // load probe instruction, then the net select
  task probe_sel(input logic [PSR_W-1:0] sel);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < IR_W; i++) step(i == IR_W - 1, IR_PROBE[i]);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < PSR_W; i++) step(i == PSR_W - 1, sel[i]);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule // jpm_host

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import jpm_pkg::*;
  logic sys_clk, rst, por, jtag, rtrst, rprobe, fuse, trst_in, ce;
  logic [7:0] usr;
  logic [15:0] nets, inv;
  logic tdo, tdo_oe, trst_o, trst_oe, pa, pa_oe, pb, pb_oe;
  logic tms_pu, tdi_pu, trst_pu, tms_av, sh_av, pp_av, pact;
  wire logic tck, tms, tdi;
  int errors = 0, checks = 0, cyc = 0;
  jpm_host host (.tck(tck), .tms(tms), .tdi(tdi));
  jpm_ctrl uut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .TCK(tck),
    .TMS(tms), .TDI(tdi), .TRST_IN(trst_in), .POR(por),
    .CFG_RESERVE_JTAG(jtag), .CFG_RESERVE_TRST(rtrst),
    .CFG_RESERVE_PROBE(rprobe), .SECURITY_FUSE(fuse), .NETS(nets),
    .USR_TDO_OUT(usr[0]), .USR_TDO_OE(usr[1]), .USR_TRST_OUT(usr[2]),
    .USR_TRST_OE(usr[3]), .USR_PROBE_A_OUT(usr[4]),
    .USR_PROBE_A_OE(usr[5]), .USR_PROBE_B_OUT(usr[6]),
    .USR_PROBE_B_OE(usr[7]), .TDO_OUT(tdo),
    .TDO_OE(tdo_oe), .TRST_OUT(trst_o), .TRST_OE(trst_oe),
    .PROBE_OUT_A(pa), .PROBE_OE_A(pa_oe), .PROBE_OUT_B(pb),
    .PROBE_OE_B(pb_oe), .TMS_PULLUP_EN(tms_pu), .TDI_PULLUP_EN(tdi_pu),
    .TRST_PULLUP_EN(trst_pu), .TMS_USER_AVAIL(tms_av),
    .SHARED_USER_AVAIL(sh_av), .PROBE_PINS_USER_AVAIL(pp_av),
    .PROBE_ACTIVE(pact), .USR_IN_VALID(inv));
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task chk(input logic [15:0] s, input logic [15:0] e, input string m);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_flex();
    chk(sh_av, 1, "user pins after power-up");
    chk(inv, 16'hffff, "user inputs valid");
    chk({tdo, tdo_oe, tms_pu, tdi_pu}, {usr[0], usr[1], 2'b00}, "tdo");
    host.claim();
    wait_n(4);
    chk({sh_av, tms_av, tdo_oe}, 0, "pins not claimed");
    chk(inv, 0, "user inputs still valid");
    host.reset5();
    wait_n(4);
    chk(sh_av, 1, "no return to user");
  endtask
  task t_probe();
    host.probe_sel(8'h53);
    wait_n(6);
    chk({pact, pa_oe, pb_oe, pp_av, sh_av}, 5'h1c, "probe pins");
    nets <= 16'h0008;
    wait_n(3);
    chk({pa, pb}, 2'b10, "net a");
    nets <= 16'h0020;
    wait_n(3);
    chk({pa, pb}, 2'b01, "net b");
    trst_in <= 1'b0;
    wait_n(4);
    chk({pact, trst_oe, trst_pu, sh_av}, 4'h3, "test reset");
    trst_in <= 1'b1;
  endtask
  task t_fuse();
    fuse <= 1'b1;
    host.probe_sel(8'h21);
    wait_n(6);
    chk(pact, 0, "probing with fuse");
    host.reset5();
    fuse <= 1'b0;
  endtask
  task t_modes();
    jtag <= 1'b1;
    wait_n(4);
    chk({tms_pu, tdi_pu, sh_av, tms_av}, 4'hc, "dedicated");
    jtag <= 1'b0;
    rtrst <= 1'b0;
    rprobe <= 1'b1;
    wait_n(2);
    chk({trst_o, trst_oe, trst_pu}, {usr[2], usr[3], 1'b0}, "trst");
    chk({pp_av, pa_oe}, 0, "probe reserve");
    rprobe <= 1'b0;
    wait_n(2);
    chk({pp_av, pa, pa_oe}, {1'b1, usr[4], usr[5]}, "probe user");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock, hang limit and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    {rst, por, rtrst, usr} = {3'b111, 8'hb6};
    ce = 1'b1;
    {jtag, rprobe, fuse, trst_in, nets} = 0;
    wait_n(12);
    {rst, por} <= 2'b00;
    trst_in <= 1'b1;
    wait_n(4);
    t_flex();
    t_probe();
    t_fuse();
    t_modes();
    wrap_up();
  end
endmodule // tb
